/* hdl/vdl_pkg.sv */
// shared constants and types for the diagnostic serial link
package vdl_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int SLOW_BAUD = 5;
  localparam int FAST_BAUD = 10400;
  localparam int SLOW_BIT_CYC = CLK_HZ / SLOW_BAUD;
  localparam int FAST_BIT_CYC = CLK_HZ / FAST_BAUD;
  localparam int TOL_PCT = 2;
  localparam logic [7:0] STD_ADDR = 8'h33;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [6:0] KEY1_DEF = 7'h08;
  localparam logic [6:0] KEY2_DEF = 7'h08;
  localparam int MSG_MIN = 5;
  localparam int MSG_MAX = 11;
  localparam int W1_CYC = 3000000;
  localparam int W2_CYC = 1000000;
  localparam int W4_CYC = 2500000;
  localparam int GAP_CYC = 2000000;
  typedef logic [7:0] vdl_byte_t;
endpackage

/* hdl/vdl_bit_if.sv */
// byte request and answer signals between the link core and the bit engine
`timescale 1ns/1ns
`default_nettype none
interface vdl_bit_if;
  logic tx_go;
  logic [7:0] tx_byte;
  logic tx_busy;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_ferr;
  logic slow;
  logic rx_en;
  modport core (output tx_go, output tx_byte, output slow, output rx_en,
                input tx_busy, input rx_done, input rx_byte, input rx_ferr);
  modport eng (input tx_go, input tx_byte, input slow, input rx_en,
               output tx_busy, output rx_done, output rx_byte, output rx_ferr);
endinterface
`default_nettype wire

/* hdl/vdl_bit_engine.sv */
// uart-style bit engine: one start, 8 data lsb first, one stop
`timescale 1ns/1ns
`default_nettype none
module vdl_bit_engine #(
  parameter int SLOW_CYC = vdl_pkg::SLOW_BIT_CYC,
  parameter int FAST_CYC = vdl_pkg::FAST_BIT_CYC
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic line_in,
  output logic tx_line_out,
  vdl_bit_if.eng bi
);
  logic [24:0] tcnt;
  logic [3:0] tbit;
  logic [9:0] tsh;
  logic [24:0] rcnt;
  logic [3:0] rbit;
  logic [7:0] rsh;
  logic ract;
  logic [24:0] bit_cyc;
  assign bit_cyc = bi.slow ? 25'(SLOW_CYC) : 25'(FAST_CYC);
  // transmit
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tcnt <= '0;
      tbit <= '0;
      tsh <= 10'h3ff;
    end else if (tbit == 4'h0) begin
      if (bi.tx_go) begin
        tsh <= {1'b1, bi.tx_byte, 1'b0};
        tbit <= 4'ha;
        tcnt <= bit_cyc - 25'h1;
      end
    end else if (tcnt == 25'h0) begin
      tsh <= {1'b1, tsh[9:1]};
      tbit <= tbit - 4'h1;
      tcnt <= bit_cyc - 25'h1;
    end else begin
      tcnt <= tcnt - 25'h1;
    end
  end
  // idle select forces a one onto the line so it rests recessive
  assign tx_line_out = (tbit == 4'h0) ? 1'b1 : tsh[0];
  assign bi.tx_busy = (tbit != 4'h0);
  // receive, sampled at mid bit for best edge margin
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ract <= 1'b0;
      rcnt <= '0;
      rbit <= '0;
      rsh <= '0;
      bi.rx_done <= 1'b0;
      bi.rx_byte <= '0;
      bi.rx_ferr <= 1'b0;
    end else begin
      bi.rx_done <= 1'b0;
      if (!ract) begin
        if (bi.rx_en && !line_in) begin
          ract <= 1'b1;
          rbit <= 4'h0;
          rcnt <= {1'b0, bit_cyc[24:1]};
        end
      end else if (rcnt == 25'h0) begin
        rcnt <= bit_cyc - 25'h1;
        rbit <= rbit + 4'h1;
        if (rbit == 4'h0 && line_in) begin
          ract <= 1'b0;
        end else if (rbit >= 4'h1 && rbit <= 4'h8) begin
          rsh <= {line_in, rsh[7:1]};
        end else if (rbit == 4'h9) begin
          ract <= 1'b0;
          bi.rx_done <= 1'b1;
          bi.rx_byte <= rsh;
          bi.rx_ferr <= !line_in;
        end
      end else begin
        rcnt <= rcnt - 25'h1;
      end
    end
  end
  tx_idle_high_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    !bi.tx_busy |-> tx_line_out) else $error("line not recessive when idle");
  start_low_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (!bi.tx_busy && bi.tx_go) |=> !tx_line_out) else $error("no start bit");
endmodule
`default_nettype wire

/* hdl/vdl_link.sv */
// diagnostic serial link, control unit end: init, header and message exchange
// Functional notes
// - slow address accepted on data line, init line, or both.
// - header and messages run at 10.4 kbit/s after initialization.
// - all bit rates within plus or minus two percent of nominal.
// - data line output rests high whenever link is idle.
// - address 33 hex selects standard protocol; others vendor formats.
// - messages are 5 to 11 bytes long; responses are cut at 11 bytes but not held to 5.
// - byte is low start, 8 data bits lsb first, high stop.
// - last byte is 8-bit sum of all preceding message bytes.
// - tester sends requests; control unit returns responses.
// - device provides data line alone or data and init lines.
// - key word is 7 bits lsb first plus odd parity.
`timescale 1ns/1ns
`default_nettype none
module vdl_link #(
  parameter int W1_CYC = vdl_pkg::W1_CYC,
  parameter int W2_CYC = vdl_pkg::W2_CYC,
  parameter int W4_CYC = vdl_pkg::W4_CYC,
  parameter int GAP_CYC = vdl_pkg::GAP_CYC,
  parameter int SLOW_CYC = vdl_pkg::SLOW_BIT_CYC,
  parameter int FAST_CYC = vdl_pkg::FAST_BIT_CYC,
  parameter logic [6:0] KEY1 = vdl_pkg::KEY1_DEF,
  parameter logic [6:0] KEY2 = vdl_pkg::KEY2_DEF
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic data_line_in,
  output logic data_line_oe_out,
  output logic data_line_out,
  input wire logic init_line_in,
  input wire logic init_line_used_in,
  output logic linked_out,
  output logic std_proto_out,
  output logic [7:0] init_addr_out,
  output logic req_valid_out,
  output logic [7:0] req_byte_out,
  output logic req_last_out,
  output logic req_err_out,
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_byte_in,
  input wire logic rsp_last_in,
  output logic rsp_ready_out
);
  typedef enum {ST_IDLE, ST_ADDR, ST_W1, ST_SYNC, ST_W2, ST_KEY1, ST_KEY2,
                ST_WINV, ST_INVA, ST_RUN, ST_RSP} vdl_state_t;
  vdl_state_t state;
  logic [2:0] d_sync, i_sync;
  logic line_lvl;
  logic [23:0] wcnt;
  logic [7:0] addr;
  logic [7:0] sum_rx, sum_tx;
  logic [3:0] rx_len, tx_len;
  logic [23:0] gap;
  logic tx_pend;
  vdl_bit_if bi ();
  vdl_bit_engine #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_eng (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .line_in(line_lvl),
    .tx_line_out(data_line_out),
    .bi(bi)
  );
  function automatic logic [7:0] key_word(input logic [6:0] k);
    key_word = {~^k, k};
  endfunction
  function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
    csum_add = 8'(a + b);
  endfunction
  // three-stage pin synchronisers; change accepted when stages two and three agree
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      d_sync <= 3'h7;
      i_sync <= 3'h7;
      line_lvl <= 1'b1;
    end else begin
      d_sync <= {d_sync[1:0], data_line_in};
      i_sync <= {i_sync[1:0], init_line_in};
      if (state == ST_IDLE || state == ST_ADDR) begin
        // either line may carry the address while init_line_used_in is set; low on either is then a zero
        if (d_sync[1] == d_sync[2] && (i_sync[1] == i_sync[2] || !init_line_used_in))
          line_lvl <= d_sync[2] & (i_sync[2] | !init_line_used_in);
      end else if (d_sync[1] == d_sync[2]) begin
        line_lvl <= d_sync[2];
      end
    end
  end
  assign bi.slow = (state == ST_IDLE || state == ST_ADDR);
  assign bi.rx_en = (state == ST_IDLE || state == ST_WINV || state == ST_RUN);
  assign data_line_oe_out = !data_line_out;
  assign rsp_ready_out = (state == ST_RSP) && !bi.tx_busy && !tx_pend;
  // bit counts are integer divisions of 100 MHz, far inside the 2 percent margin
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      wcnt <= '0;
      addr <= '0;
      tx_pend <= 1'b0;
      bi.tx_go <= 1'b0;
      bi.tx_byte <= 8'hff;
      sum_tx <= '0;
      tx_len <= '0;
    end else begin
      bi.tx_go <= 1'b0;
      if (wcnt != 24'h0)
        wcnt <= wcnt - 24'h1;
      unique case (state)
        ST_IDLE: if (bi.rx_done) begin
          addr <= bi.rx_byte;
          state <= bi.rx_ferr ? ST_IDLE : ST_W1;
          wcnt <= 24'(W1_CYC);
        end
        ST_ADDR: state <= ST_IDLE;
        ST_W1: if (wcnt == 24'h0) begin
          bi.tx_byte <= vdl_pkg::SYNC_BYTE;
          bi.tx_go <= 1'b1;
          state <= ST_SYNC;
        end
        ST_SYNC: if (!bi.tx_go && !bi.tx_busy) begin
          wcnt <= 24'(W2_CYC);
          state <= ST_W2;
        end
        ST_W2: if (wcnt == 24'h0) begin
          bi.tx_byte <= key_word(KEY1);
          bi.tx_go <= 1'b1;
          state <= ST_KEY1;
        end
        ST_KEY1: if (!bi.tx_go && !bi.tx_busy) begin
          bi.tx_byte <= key_word(KEY2);
          bi.tx_go <= 1'b1;
          state <= ST_KEY2;
        end
        ST_KEY2: if (!bi.tx_go && !bi.tx_busy) begin
          wcnt <= 24'(W4_CYC);
          state <= ST_WINV;
        end
        ST_WINV: if (bi.rx_done) begin
          if (bi.rx_byte == ~key_word(KEY2)) begin
            bi.tx_byte <= ~addr;
            bi.tx_go <= 1'b1;
            state <= ST_INVA;
          end else begin
            state <= ST_IDLE;
          end
        end else if (wcnt == 24'h0) begin
          state <= ST_IDLE;
        end
        ST_INVA: if (!bi.tx_go && !bi.tx_busy)
          state <= ST_RUN;
        ST_RUN: if (gap == 24'h0 && rx_len == 4'h0)
          state <= ST_IDLE;
        else if (req_valid_out && req_last_out) begin
          state <= ST_RSP;
          sum_tx <= '0;
          tx_len <= '0;
        end
        ST_RSP: begin
          if (rsp_valid_in && rsp_ready_out) begin
            bi.tx_go <= 1'b1;
            tx_pend <= 1'b1;
            tx_len <= tx_len + 4'h1;
            // last data byte is followed by the computed checksum byte
            if (rsp_last_in || tx_len == 4'(vdl_pkg::MSG_MAX - 2)) begin
              bi.tx_byte <= rsp_byte_in;
              sum_tx <= csum_add(sum_tx, rsp_byte_in);
              tx_len <= 4'hf;
            end else begin
              bi.tx_byte <= rsp_byte_in;
              sum_tx <= csum_add(sum_tx, rsp_byte_in);
            end
          end else if (tx_pend && !bi.tx_go && !bi.tx_busy) begin
            tx_pend <= 1'b0;
            if (tx_len == 4'hf) begin
              bi.tx_byte <= sum_tx;
              bi.tx_go <= 1'b1;
              tx_len <= 4'he;
              tx_pend <= 1'b1;
            end else if (tx_len == 4'he) begin
              state <= ST_RUN;
            end
          end
        end
      endcase
    end
  end
  // request side: gap of line silence closes a message
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      gap <= 24'(GAP_CYC);
      rx_len <= '0;
      sum_rx <= '0;
      req_valid_out <= 1'b0;
      req_byte_out <= '0;
      req_last_out <= 1'b0;
      req_err_out <= 1'b0;
    end else begin
      req_valid_out <= 1'b0;
      req_last_out <= 1'b0;
      if (state != ST_RUN) begin
        gap <= 24'(GAP_CYC);
        rx_len <= '0;
        sum_rx <= '0;
      end else if (bi.rx_done) begin
        gap <= 24'(FAST_CYC * 2);
        req_valid_out <= 1'b1;
        req_byte_out <= bi.rx_byte;
        rx_len <= (rx_len == 4'hf) ? rx_len : rx_len + 4'h1;
        sum_rx <= csum_add(sum_rx, bi.rx_byte);
        req_err_out <= 1'b0;
      end else if (gap != 24'h0) begin
        // silence counts only while the line rests high; a byte in flight reloads it
        gap <= line_lvl ? gap - 24'h1 : 24'(FAST_CYC * 11);
      end else if (rx_len != 4'h0) begin
        // last byte received is the checksum; compare against sum of the rest
        req_valid_out <= 1'b1;
        req_last_out <= 1'b1;
        req_err_out <= (csum_add(sum_rx, ~req_byte_out + 8'h01) != req_byte_out)
          || rx_len < 4'(vdl_pkg::MSG_MIN) || rx_len > 4'(vdl_pkg::MSG_MAX);
        rx_len <= '0;
        sum_rx <= '0;
        gap <= 24'(GAP_CYC);
      end
    end
  end
  assign linked_out = (state == ST_RUN || state == ST_RSP);
  assign std_proto_out = linked_out && (addr == vdl_pkg::STD_ADDR);
  assign init_addr_out = addr;
  inv_addr_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state == ST_WINV && bi.rx_done && bi.rx_byte == ~key_word(KEY2))
    |=> bi.tx_go && bi.tx_byte == ~addr) else $error("inverted address not sent");
  key_par_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (bi.tx_go && (state == ST_KEY1 || state == ST_KEY2)) |-> ^bi.tx_byte)
    else $error("key word parity even");
  fast_rate_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    linked_out |-> !bi.slow) else $error("slow rate after init");
  std_sel_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    std_proto_out |-> addr == 8'h33) else $error("standard mode on wrong address");
  oe_low_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    data_line_oe_out |-> !data_line_out) else $error("driving a high level");
  len_err_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state == ST_RUN && gap == 24'h0 && rx_len > 4'h0 && rx_len < 4'h5 && !bi.rx_done)
    |=> req_last_out && req_err_out) else $error("short message not flagged");
  cs_last_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state == ST_RSP && tx_pend && tx_len == 4'hf && !bi.tx_go && !bi.tx_busy)
    |=> bi.tx_go && bi.tx_byte == $past(sum_tx)) else $error("checksum not sent last");
  rsp_after_req_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state == ST_RUN && req_valid_out && req_last_out) |=> state == ST_RSP)
    else $error("no response phase");
  link_up_c: cover property (@(posedge mclk_in) disable iff (srst_in) $rose(linked_out));
  req_ok_c: cover property (@(posedge mclk_in) disable iff (srst_in)
    req_last_out && !req_err_out);
  rsp_sent_c: cover property (@(posedge mclk_in) disable iff (srst_in)
    state == ST_RSP ##1 state == ST_RUN);
endmodule
`default_nettype wire

/* tb/vdl_tester.sv */
// behavioural diagnostic tester driving the data and init lines
`timescale 1ns/1ns
`default_nettype none
module vdl_tester (
  input wire logic mclk_in,
  input wire logic k_in,
  output logic k_out,
  output logic l_out
);
  initial begin
    k_out = 1'b1;
    l_out = 1'b1;
  end
  // low start, 8 bits lsb first, high stop; unused line rests at pull-up level
  task automatic tx(input logic [7:0] b, input int cyc, input logic [1:0] ln);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk_in);
      k_out = ln[0] ? f[i] : 1'b1;
      l_out = ln[1] ? f[i] : 1'b1;
      repeat (cyc - 1) @(negedge mclk_in);
    end
  endtask
  // mid-bit sampling keeps edges shifted by up to 30 percent decodable
  task automatic rx(input int cyc, input int lim, output logic [7:0] b, output logic ok,
                    output int lo);
    int n;
    ok = 1'b0;
    b = 8'h00;
    lo = 1;
    n = 0;
    while (k_in !== 1'b0 && n < lim) begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= lim) return;
    for (int c = 1; c <= cyc * 9 + cyc / 2; c++) begin
      @(negedge mclk_in);
      if (k_in === 1'b0 && lo == c) lo++;
      if (c % cyc == cyc / 2 && c > cyc && c < cyc * 9) b[c / cyc - 1] = k_in;
    end
    ok = (k_in === 1'b1);
  endtask
endmodule
`default_nettype wire

/* tb/vdl_link_tb.sv */
// self-checking bench for the control unit end of the diagnostic link
`timescale 1ns/1ns
`default_nettype none
module vdl_link_tb;
  localparam int SC = 200;
  localparam int FC = 20;
  localparam int WC = 500;
  localparam int GC = 2000;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic used = 1'b1;
  logic rsp_valid = 1'b0;
  logic [7:0] rsp_byte = 8'h00;
  logic rsp_last = 1'b0;
  logic oe, dout, linked, stdp, rv, rl, re, rdy, tk, tl, k;
  logic [7:0] iaddr, rb;
  int failures = 0;
  int comparisons = 0;
  int last_n = 0;
  vdl_pkg::vdl_byte_t got_q[$];
  vdl_pkg::vdl_byte_t last_b;
  logic last_err;
  vdl_pkg::vdl_byte_t rsp[4] = '{8'h48, 8'h6b, 8'h11, 8'h41};
  // open drain: either party pulls the line low
  assign k = tk & ~oe;
  always #5 mclk_in = ~mclk_in;
  vdl_link #(.W1_CYC(WC), .W2_CYC(WC), .W4_CYC(WC), .GAP_CYC(GC), .SLOW_CYC(SC),
    .FAST_CYC(FC)) dut (.mclk_in(mclk_in), .srst_in(srst_in), .data_line_in(k),
    .data_line_oe_out(oe), .data_line_out(dout), .init_line_in(tl),
    .init_line_used_in(used), .linked_out(linked), .std_proto_out(stdp),
    .init_addr_out(iaddr), .req_valid_out(rv), .req_byte_out(rb), .req_last_out(rl),
    .req_err_out(re), .rsp_valid_in(rsp_valid), .rsp_byte_in(rsp_byte),
    .rsp_last_in(rsp_last), .rsp_ready_out(rdy));
  vdl_tester tst (.mclk_in(mclk_in), .k_in(k), .k_out(tk), .l_out(tl));
  always @(posedge mclk_in) begin
    if (rv === 1'b1 && rl === 1'b1) begin
      last_b <= rb;
      last_err <= re;
      last_n <= last_n + 1;
    end else if (rv === 1'b1) begin
      got_q.push_back(rb);
    end
  end
  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fail_out();
    failures++;
    summarize();
  endtask
  task automatic rxb(input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    int lo;
    tst.rx(FC, 5000, b, ok, lo);
    if (ok !== 1'b1) fail_out();
    check(b, exp);
  endtask
  task automatic do_reset(input logic u);
    @(negedge mclk_in);
    srst_in = 1'b1;
    used = u;
    repeat (12) @(negedge mclk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    check(dout, 1'b1);
    check(oe, 1'b0);
  endtask
  task automatic do_init(input logic [7:0] a, input logic [1:0] ln, input logic [7:0] ans);
    logic [7:0] b;
    logic ok;
    int lo;
    tst.tx(a, SC, ln);
    tst.rx(FC, 5000, b, ok, lo);
    if (ok !== 1'b1) fail_out();
    check(b, vdl_pkg::SYNC_BYTE);
    check(lo, FC);
    rxb(8'h08);
    rxb(8'h08);
    repeat (FC) @(negedge mclk_in);
    tst.tx(ans, FC, 2'b01);
  endtask
  task automatic t_modes();
    logic [7:0] a;
    for (int m = 1; m < 4; m++) begin
      a = (m == 2) ? 8'h5a : 8'h33;
      do_reset(m != 1);
      do_init(a, m[1:0], 8'hf7);
      rxb(~a);
      repeat (FC) @(negedge mclk_in);
      check(linked, 1'b1);
      check(stdp, a == 8'h33);
      check(iaddr, a);
    end
  endtask
  task automatic t_bad_key();
    logic [7:0] b;
    logic ok;
    int lo;
    do_reset(1'b1);
    do_init(8'h33, 2'b11, 8'h00);
    tst.rx(FC, 2000, b, ok, lo);
    check(ok, 1'b0);
    check(linked, 1'b0);
  endtask
  // request, then response with appended checksum 48+6b+11+41 wrapped to 05
  task automatic exchange(input vdl_pkg::vdl_byte_t q[$], input logic err);
    int n;
    int n0;
    got_q.delete();
    n0 = last_n;
    repeat (FC) @(negedge mclk_in);
    foreach (q[i]) tst.tx(q[i], FC, 2'b01);
    n = 0;
    while (last_n == n0 && n < 500) begin
      @(negedge mclk_in);
      n++;
    end
    if (n >= 500) fail_out();
    check(got_q.size(), q.size());
    for (int i = 0; i < q.size() && i < got_q.size(); i++) check(got_q[i], q[i]);
    check(last_b, q[q.size() - 1]);
    check(last_err, err);
    fork
      begin
        for (int i = 0; i < 4; i++) begin
          @(negedge mclk_in);
          rsp_valid = 1'b1;
          rsp_byte = rsp[i];
          rsp_last = (i == 3);
          n = 0;
          while (rdy !== 1'b1 && n < 5000) begin
            @(negedge mclk_in);
            n++;
          end
          if (n >= 5000) fail_out();
          @(posedge mclk_in);
        end
        @(negedge mclk_in);
        rsp_valid = 1'b0;
        rsp_last = 1'b0;
      end
      begin
        for (int i = 0; i < 5; i++) rxb(i < 4 ? rsp[i] : 8'h05);
      end
    join
  endtask
  task automatic t_traffic();
    do_reset(1'b1);
    do_init(8'h33, 2'b11, 8'hf7);
    rxb(8'hcc);
    exchange({8'h68, 8'h6a, 8'hf1, 8'h01, 8'h00, 8'hc4}, 1'b0);
    exchange({8'h68, 8'h6a, 8'hf1, 8'h01, 8'h00, 8'hc5}, 1'b1);
    exchange({8'h01, 8'h02, 8'h03, 8'h06}, 1'b1);
    repeat (GC + 200) @(negedge mclk_in);
    check(linked, 1'b0);
    check(dout, 1'b1);
  endtask
  initial begin
    do_reset(1'b1);
    t_modes();
    t_bad_key();
    t_traffic();
    summarize();
  end
endmodule
`default_nettype wire
